// *** inc/csvc_pkg.sv ***
// package for the comparator sync, gate select and voltage reference control block
package csvc_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [1:0] CSVC_ADDR_GATE_SYNC = 2'h0; // comparator_gate_sync_config
    localparam logic [1:0] CSVC_ADDR_VREF = 2'h1; // voltage_reference_control
    localparam logic [1:0] CSVC_ADDR_STATUS = 2'h2; // read-only live state

    // ****************************************
    // field positions
    // ****************************************
    localparam int CSVC_SYNC_BIT = 0;
    localparam int CSVC_GSS_BIT = 1;
    localparam int CSVC_VREF_POWER_ON_BIT = 7;
    localparam int CSVC_VRR_BIT = 5;
    localparam int CSVC_VR_LSB = 0;

    // ****************************************
    // reset values and masks
    // ****************************************
    localparam logic [7:0] CSVC_GATE_SYNC_RST = 8'h02;
    localparam logic [7:0] CSVC_VREF_RST = 8'h00;
    localparam logic [7:0] CSVC_GATE_SYNC_MASK = 8'h03;
    localparam logic [7:0] CSVC_VREF_MASK = 8'haf;

    // ****************************************
    // ladder arithmetic: reference = num / den of the ladder top
    // ****************************************
    localparam logic [5:0] CSVC_LOW_DEN = 6'h18; // 24 steps
    localparam logic [5:0] CSVC_HIGH_DEN = 6'h20; // 32 steps
    localparam logic [5:0] CSVC_HIGH_BASE = 6'h08; // one quarter of 32

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } csvc_bus_t;

    typedef struct packed {
        logic power_on;
        logic range_low;
        logic [3:0] level_code;
        logic [5:0] num;
        logic [5:0] den;
        logic clamp_gnd;
    } csvc_vref_t;
endpackage : csvc_pkg

// *** rtl/csvc_top.sv ***
// comparator to gated counter sync, gate source select and voltage reference control
`timescale 1ns/100ps
module csvc_top
    import csvc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire csvc_pkg::csvc_bus_t bus,
    output logic [7:0] rdata,
    input wire logic cnt_clk_src,
    input wire logic prescaler_out,
    input wire logic prescale_on,
    input wire logic counter_on,
    input wire logic gating_en,
    input wire logic cmp_out,
    input wire logic counter_gate_pin,
    output logic counter_gate,
    output logic counter_inc,
    output csvc_pkg::csvc_vref_t vref
);
    import csvc_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic cmp_out_sync_sel;
        logic gate_source_select;
        logic vref_power_on;
        logic vref_range_low;
        logic [3:0] vref_level_code;
        logic cnt_clk_d;
        logic cmp_latch;
        logic [7:0] rdata;
    } csvc_state_t;

    csvc_state_t st_r;
    csvc_state_t st_nxt;
    logic tick_clk;
    logic fall_edge;
    logic rise_edge;
    logic cmp_path;

    // reference fraction; ladder numerator over denominator keeps analog side simple
    function automatic logic [5:0] csvc_num(input logic lo, input logic [3:0] code);
        csvc_num = lo ? {2'h0, code} : CSVC_HIGH_BASE + {2'h0, code};
    endfunction : csvc_num

    // ****************************************
    // counter clock edges
    // ****************************************
    // the prescaled clock feeds the latch whenever the prescaler is in use
    assign tick_clk = prescale_on ? prescaler_out : cnt_clk_src;
    assign fall_edge = st_r.cnt_clk_d & ~tick_clk;
    assign rise_edge = ~st_r.cnt_clk_d & tick_clk;
    // counting on the rising edge while the latch moves only on the falling one
    assign counter_inc = rise_edge & counter_on & counter_gate;

    // ****************************************
    // gate path
    // ****************************************
    // unsynced path is combinational, so a mid-increment toggle can drop a count
    assign cmp_path = st_r.cmp_out_sync_sel ? st_r.cmp_latch : cmp_out;
    always_comb begin
        if (!counter_on || !gating_en) begin
            counter_gate = 1'b1; // ungated counting
        end else if (st_r.gate_source_select) begin
            counter_gate = counter_gate_pin;
        end else begin
            counter_gate = cmp_path;
        end
    end

    // ****************************************
    // reference outputs
    // ****************************************
    always_comb begin
        vref.power_on = st_r.vref_power_on;
        vref.range_low = st_r.vref_range_low;
        vref.level_code = st_r.vref_level_code;
        vref.num = csvc_num(st_r.vref_range_low, st_r.vref_level_code);
        vref.den = st_r.vref_range_low ? CSVC_LOW_DEN : CSVC_HIGH_DEN;
        vref.clamp_gnd = ~st_r.vref_power_on & st_r.vref_range_low
            & (st_r.vref_level_code == 4'h0);
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.cnt_clk_d = tick_clk;
        // latch holds between falling edges
        if (fall_edge) begin
            st_nxt.cmp_latch = cmp_out;
        end
        if (bus.wr) begin
            unique case (bus.addr)
                CSVC_ADDR_GATE_SYNC: begin
                    st_nxt.cmp_out_sync_sel = bus.wdata[CSVC_SYNC_BIT];
                    st_nxt.gate_source_select = bus.wdata[CSVC_GSS_BIT];
                end
                CSVC_ADDR_VREF: begin
                    st_nxt.vref_power_on = bus.wdata[CSVC_VREF_POWER_ON_BIT];
                    st_nxt.vref_range_low = bus.wdata[CSVC_VRR_BIT];
                    st_nxt.vref_level_code = bus.wdata[CSVC_VR_LSB +: 4];
                end
                default: begin
                end
            endcase
        end
        st_nxt.rdata = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                CSVC_ADDR_GATE_SYNC: begin
                    st_nxt.rdata = {6'h00, st_r.gate_source_select, st_r.cmp_out_sync_sel};
                end
                CSVC_ADDR_VREF: begin
                    st_nxt.rdata = {st_r.vref_power_on, 1'b0, st_r.vref_range_low, 1'b0,
                        st_r.vref_level_code};
                end
                CSVC_ADDR_STATUS: begin
                    st_nxt.rdata = {5'h00, counter_gate, cmp_path, st_r.cmp_latch};
                end
                default: begin
                    st_nxt.rdata = 8'h00; // unmapped reads zero
                end
            endcase
        end
    end

    // state register; latch clears on reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r.cmp_out_sync_sel <= CSVC_GATE_SYNC_RST[CSVC_SYNC_BIT];
            st_r.gate_source_select <= CSVC_GATE_SYNC_RST[CSVC_GSS_BIT];
            st_r.vref_power_on <= CSVC_VREF_RST[CSVC_VREF_POWER_ON_BIT];
            st_r.vref_range_low <= CSVC_VREF_RST[CSVC_VRR_BIT];
            st_r.vref_level_code <= CSVC_VREF_RST[3:0];
            st_r.cnt_clk_d <= 1'b0;
            st_r.cmp_latch <= 1'b0;
            st_r.rdata <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
endmodule : csvc_top

// *** testbench/csvc_partner.sv ***
// counter clock source model
`timescale 1ns/100ps
module csvc_partner (
    input wire logic clk,
    input wire logic run,
    output logic raw_clk,
    output logic div_clk
);
    // ****
    // raw clock clk/4, prescaled clk/8; both stand low while stopped
    // ****
    logic [2:0] cnt_r;
    always_ff @(posedge clk) cnt_r <= run ? cnt_r + 3'h1 : 3'h0;
    assign raw_clk = cnt_r[1];
    assign div_clk = cnt_r[2];
endmodule : csvc_partner

// *** testbench/csvc_top_asserts.sv ***
// concurrent checks at the ports of csvc_top
`timescale 1ns/100ps
module csvc_top_asserts
    import csvc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire csvc_pkg::csvc_bus_t bus,
    input wire logic [7:0] rdata,
    input wire logic cnt_clk_src,
    input wire logic prescaler_out,
    input wire logic prescale_on,
    input wire logic counter_on,
    input wire logic gating_en,
    input wire logic cmp_out,
    input wire logic counter_gate_pin,
    input wire logic counter_gate,
    input wire logic counter_inc,
    input wire csvc_pkg::csvc_vref_t vref
);
    // ****
    // shadow of select and sync bits, since the register is inside
    // ****
    logic [1:0] gs_r;
    wire logic ck = prescale_on ? prescaler_out : cnt_clk_src;
    wire logic en = counter_on && gating_en;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) gs_r <= 2'h2;
        else if (bus.wr && bus.addr == CSVC_ADDR_GATE_SYNC) gs_r <= bus.wdata[1:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_rd_upper: assert property (bus.rd && bus.addr == 2'h0 |=> rdata[7:2] == 6'h00)
        else $error("upper bits set");
    a_gate_idle: assert property (!en |-> counter_gate)
        else $error("gate low while idle");
    a_gate_pin: assert property (en && gs_r[1] |-> counter_gate == counter_gate_pin)
        else $error("gate not pin");
    a_gate_async: assert property (en && gs_r == 2'h0 |-> counter_gate == cmp_out)
        else $error("gate not comparator");
    a_inc_rise: assert property (counter_inc |-> counter_on && counter_gate && ck && !$past(ck))
        else $error("stray increment");
    a_inc_each: assert property (counter_on && counter_gate && $rose(ck) |-> counter_inc)
        else $error("missed increment");
    a_sync_cap: assert property ($fell(ck) ##1 (en && gs_r == 2'h1) |-> counter_gate == $past(cmp_out))
        else $error("latch missed fall");
    a_sync_hold: assert property ((en && gs_r == 2'h1 && !$fell(ck)) ##1 (en && gs_r == 2'h1) |-> $stable(counter_gate))
        else $error("latch moved");
    a_vref_clamp: assert property (vref.clamp_gnd == (!vref.power_on && vref.range_low && vref.level_code == 4'h0))
        else $error("clamp wrong");
endmodule : csvc_top_asserts
bind csvc_top csvc_top_asserts u_chk (.clk, .rst, .bus, .rdata, .cnt_clk_src, .prescaler_out, .prescale_on,
    .counter_on, .gating_en, .cmp_out, .counter_gate_pin, .counter_gate, .counter_inc, .vref);

// *** testbench/csvc_top_tb.sv ***
// self-checking bench for csvc_top
`timescale 1ns/100ps
module csvc_top_tb;
    import csvc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, run = 1'b0, pon = 1'b0, con = 1'b0, gen = 1'b0, cmp = 1'b0, pin = 1'b1;
    logic raw, div, gate, inc;
    logic [7:0] rdata;
    csvc_bus_t bus = '0;
    csvc_vref_t vref;
    int bad_count = 0, checks_done = 0, n;
    always #20 clk = ~clk;
    csvc_partner i_csvc_partner (.clk, .run, .raw_clk(raw), .div_clk(div));
    csvc_top i_csvc_top (.clk, .rst, .bus, .rdata, .cnt_clk_src(raw), .prescaler_out(div), .prescale_on(pon),
        .counter_on(con), .gating_en(gen), .cmp_out(cmp), .counter_gate_pin(pin), .counter_gate(gate),
        .counter_inc(inc), .vref);
    // ****
    // access and compare tasks
    // ****
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) bus <= '0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) bus <= '0;
        @(negedge clk) chk(rdata, exp);
    endtask : rd
    // a 64-cycle window holds an exact number of rises whatever the phase
    task automatic cnt(input logic [7:0] exp);
        n = 0;
        repeat (64) @(negedge clk) n += (inc === 1'b1);
        chk(8'(n), exp);
    endtask : cnt
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(CSVC_ADDR_GATE_SYNC, 8'h02);
        wr(CSVC_ADDR_VREF, 8'hff);
        rd(CSVC_ADDR_VREF, 8'haf);
        wr(2'h3, 8'h00);
        rd(2'h3, 8'h00);
        for (int i = 0; i < 32; i++) begin
            wr(CSVC_ADDR_VREF, {i[0], 1'b0, i[4], 1'b0, i[3:0]});
            @(negedge clk) chk({2'h0, vref.num}, i[4] ? {4'h0, i[3:0]} : 8'h08 + i[3:0]);
            chk({2'h0, vref.den}, i[4] ? 8'h18 : 8'h20);
            chk(vref.power_on, i[0]);
            chk(vref.clamp_gnd, i[4] && !i[0] && i[3:0] == 0);
        end
        wr(CSVC_ADDR_GATE_SYNC, 8'hff);
        rd(CSVC_ADDR_GATE_SYNC, 8'h03);
        @(posedge clk);
        con <= 1'b1;
        gen <= 1'b1;
        for (int v = 0; v < 2; v++) begin
            @(posedge clk) pin <= v[0];
            @(negedge clk) chk(gate, v[0]);
        end
        @(posedge clk) run <= 1'b1;
        cnt(8'd16);
        @(posedge clk) pon <= 1'b1;
        repeat (8) @(posedge clk);
        cnt(8'd8);
        wr(CSVC_ADDR_GATE_SYNC, 8'h00);
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk) cmp <= v[0];
            @(negedge clk) chk(gate, v[0]);
        end
        repeat (16) @(posedge clk);
        run <= 1'b0;
        wr(CSVC_ADDR_GATE_SYNC, 8'h01);
        cmp <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk) chk(gate, 1'b0);
        @(posedge clk) run <= 1'b1;
        repeat (16) @(posedge clk);
        @(negedge clk) chk(gate, 1'b1);
        rd(CSVC_ADDR_STATUS, 8'h07);
        end_sim();
    end
    // the tests take under 1000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        end_sim();
    end
endmodule : csvc_top_tb
